// [rtl/reset_init_sequencer.sv]
// Reset request gathering, settling wait and initial-state command generation
//
// Added by the designer: the address map and the plain strobed port.
module reset_init_sequencer #(
  parameter int SETTLE_DIV    = reset_init_pkg::SETTLE_DIV_DEF,    // Timer 1 source divider
  parameter int SETTLE_PULSES = reset_init_pkg::SETTLE_PULSES_DEF  // Timer 1 pulses to count
) (
  input  wire logic                       mclk,          // 200 MHz system clock
  input  wire logic                       nrst,          // Synchronous, active low
  input  wire logic                       reset_pin_n,   // External reset pin, asynchronous
  input  wire logic                       supply_low,    // supply_detector comparator output
  input  wire logic                       int_pin,       // External interrupt pin level
  input  wire logic                       wdt_overflow,  // Watchdog overflow pulse, same clock
  input  wire logic                       stack_fault,   // Stack over/underflow pulse
  input  wire logic                       standby,       // Core is in HALT or STOP
  input  wire logic [3:0]                 reg_addr,      // Register byte address
  input  wire logic [7:0]                 reg_wdata,     // Register write data
  input  wire logic                       reg_wr,        // Write strobe
  input  wire logic                       reg_rd,        // Read strobe
  output logic [7:0]                      reg_rdata,     // Read data, cycle after strobe
  output logic                            core_hold,     // Core held, no fetch
  output logic                            int_level,     // Mirror of the interrupt pin
  output reset_init_pkg::init_cmd_t       init_cmd       // Initial state command
);

  // Elaboration checks: counters need powers of two, at least two
  if (SETTLE_DIV < 2 || (SETTLE_DIV & (SETTLE_DIV - 1)) != 0) begin : g_div_chk
    $error("SETTLE_DIV must be a power of two of at least 2");
  end
  if (SETTLE_PULSES < 2 || (SETTLE_PULSES & (SETTLE_PULSES - 1)) != 0) begin : g_pul_chk
    $error("SETTLE_PULSES must be a power of two of at least 2");
  end

  localparam int PRE_W = $clog2(SETTLE_DIV);
  localparam int CNT_W = $clog2(SETTLE_PULSES);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(SETTLE_DIV - 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SETTLE_PULSES - 1);

  // Pin synchronisers: three stages, agreed value follows when stages two and three agree
  logic [2:0] s1_r, s2_r, s3_r;         // Shift stages
  logic [2:0] pins_r, pins_nxt;         // Agreed pin levels

  // Software registers
  logic       det_en_r, det_en_nxt;     // supply_detector enable
  logic [7:0] width_r, width_nxt;       // Detection pulse width in cycles
  logic [3:0] cause_r, cause_nxt;       // Sticky reset causes
  logic [7:0] rdata_nxt;

  // Supply filter
  logic [7:0] low_cnt_r, low_cnt_nxt;   // Cycles the supply has stayed low
  logic       sup_req_r, sup_req_nxt;   // Filtered supply reset request

  // Sequencer
  reset_init_pkg::seq_state_t state_r, state_nxt;
  logic       power_r, power_nxt;       // Pin or supply reset seen
  logic       wdt_r, wdt_nxt;           // Watchdog overflow seen
  logic       stby_r, stby_nxt;         // Reset arrived in standby
  logic [PRE_W-1:0] pre_r, pre_nxt;     // Divide-by prescaler for timer 1
  logic [CNT_W-1:0] t1_r, t1_nxt;       // Timer 1 settling count
  logic       hold_nxt;
  reset_init_pkg::init_cmd_t cmd_nxt;

  // Request terms
  logic pin_req, any_req, settle_done;

  // Agreed levels move only when the last two stages match, filtering one-stage glitches
  always_comb begin
    pins_nxt = ((s2_r ~^ s3_r) & s3_r) | (~(s2_r ~^ s3_r) & pins_r);
  end

  // Synchroniser registers
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s1_r   <= reset_init_pkg::PIN_IDLE;
      s2_r   <= reset_init_pkg::PIN_IDLE;
      s3_r   <= reset_init_pkg::PIN_IDLE;
      pins_r <= reset_init_pkg::PIN_IDLE;
    end else begin
      s1_r   <= {int_pin, supply_low, reset_pin_n};
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      pins_r <= pins_nxt;
    end
  end

  // Supply filter: a short dip never resets, rising supply releases at once
  always_comb begin
    low_cnt_nxt = 8'h00;
    sup_req_nxt = 1'b0;
    if (det_en_r && pins_r[reset_init_pkg::PIN_SUP_LOW]) begin
      low_cnt_nxt = (low_cnt_r == 8'hff) ? low_cnt_r : low_cnt_r + 8'h01;
      sup_req_nxt = (low_cnt_r >= width_r);
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      low_cnt_r <= 8'h00;
      sup_req_r <= 1'b0;
    end else begin
      low_cnt_r <= low_cnt_nxt;
      sup_req_r <= sup_req_nxt;
    end
  end

  // Request combination
  always_comb begin
    pin_req     = !pins_r[reset_init_pkg::PIN_RESET_N];
    any_req     = pin_req | sup_req_r | wdt_overflow | stack_fault;
    settle_done = (pre_r == PRE_LAST) && (t1_r == CNT_LAST);
  end

  // Sequencer next state and reset-type record
  always_comb begin
    state_nxt = state_r;
    power_nxt = power_r;
    wdt_nxt   = wdt_r;
    stby_nxt  = stby_r;
    pre_nxt   = '0;
    t1_nxt    = '0;
    if (any_req) begin
      state_nxt = reset_init_pkg::ST_HOLD;
      // Type accumulates until running, so an unfinished power start keeps its wait
      if (state_r == reset_init_pkg::ST_RUN) begin
        power_nxt = pin_req | sup_req_r;
        wdt_nxt   = wdt_overflow;
        stby_nxt  = standby;
      end else begin
        power_nxt = power_r | pin_req | sup_req_r;
        wdt_nxt   = wdt_r | wdt_overflow;
      end
    end else begin
      unique case (state_r)
        reset_init_pkg::ST_HOLD: begin
          state_nxt = reset_init_pkg::ST_INIT;
        end
        reset_init_pkg::ST_INIT: begin
          // Power class waits for the oscillator, soft class starts at once
          state_nxt = power_r ? reset_init_pkg::ST_SETTLE
                              : reset_init_pkg::ST_RUN;
        end
        reset_init_pkg::ST_SETTLE: begin
          pre_nxt = pre_r + PRE_W'(1);
          t1_nxt  = (pre_r == PRE_LAST) ? t1_r + CNT_W'(1) : t1_r;
          if (settle_done) begin
            state_nxt = reset_init_pkg::ST_RUN;
          end
        end
        reset_init_pkg::ST_RUN: begin
          state_nxt = reset_init_pkg::ST_RUN;
        end
      endcase
    end
    hold_nxt = (state_nxt != reset_init_pkg::ST_RUN);
  end

  // Initial-state command, issued as the sequencer enters INIT
  always_comb begin
    cmd_nxt = '0;
    if (state_r == reset_init_pkg::ST_HOLD && !any_req) begin
      cmd_nxt.apply                   = 1'b1;
      cmd_nxt.full_ctrl               = power_r;
      cmd_nxt.pc_start                = reset_init_pkg::PC_START_VAL;
      cmd_nxt.stack_index             = reset_init_pkg::STACK_INIT_VAL;
      cmd_nxt.timer1_irq_flag         = power_r;
      cmd_nxt.timer1_run_enable       = power_r;
      cmd_nxt.interval_timer_irq_flag = 1'b0;
      cmd_nxt.ports_input             = 1'b1;
      cmd_nxt.port_latch_clear        = power_r;
      cmd_nxt.keep_memory             = power_r & stby_r;
      cmd_nxt.keep_window             = power_r & stby_r;
      cmd_nxt.keep_shift              = power_r & stby_r;
      cmd_nxt.timer0_clear            = 1'b1;
      cmd_nxt.timer1_clear            = power_r;
      cmd_nxt.modulo_value            = reset_init_pkg::MODULO_INIT_VAL;
      cmd_nxt.bitcnt_load             = wdt_r;
      cmd_nxt.bitcnt_value            = reset_init_pkg::BITCNT_WDT_VAL;
      cmd_nxt.conv_result_clear       = 1'b1;
    end
  end

  // Sequencer registers; power-up behaves as a pin reset so the first start settles
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_r   <= reset_init_pkg::ST_HOLD;
      power_r   <= 1'b1;
      wdt_r     <= 1'b0;
      stby_r    <= 1'b0;
      pre_r     <= '0;
      t1_r      <= '0;
      core_hold <= 1'b1;
      init_cmd  <= '0;
      int_level <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      power_r   <= power_nxt;
      wdt_r     <= wdt_nxt;
      stby_r    <= stby_nxt;
      pre_r     <= pre_nxt;
      t1_r      <= t1_nxt;
      core_hold <= hold_nxt;
      init_cmd  <= cmd_nxt;
      int_level <= pins_r[reset_init_pkg::PIN_INT];
    end
  end

  // Register port: writes, sticky causes and read mux
  always_comb begin
    det_en_nxt = det_en_r;
    width_nxt  = width_r;
    cause_nxt  = cause_r;
    rdata_nxt  = 8'h00;  // Unmapped and idle cycles read zero
    if (reg_wr) begin
      unique case (reg_addr)
        reset_init_pkg::CTRL_ADDR:  det_en_nxt = reg_wdata[reset_init_pkg::CTRL_DET_EN_BIT];
        reset_init_pkg::WIDTH_ADDR: width_nxt  = reg_wdata;
        reset_init_pkg::CAUSE_ADDR: cause_nxt  = cause_r & ~reg_wdata[3:0];
        default:                    cause_nxt  = cause_r;
      endcase
    end
    // Hardware set applied after the clear so a same-cycle event survives
    cause_nxt[reset_init_pkg::CAUSE_PIN_BIT] = cause_nxt[reset_init_pkg::CAUSE_PIN_BIT] | pin_req;
    cause_nxt[reset_init_pkg::CAUSE_SUP_BIT] = cause_nxt[reset_init_pkg::CAUSE_SUP_BIT] | sup_req_r;
    cause_nxt[reset_init_pkg::CAUSE_WDT_BIT] = cause_nxt[reset_init_pkg::CAUSE_WDT_BIT]
                                               | wdt_overflow;
    cause_nxt[reset_init_pkg::CAUSE_STK_BIT] = cause_nxt[reset_init_pkg::CAUSE_STK_BIT]
                                               | stack_fault;
    if (reg_rd) begin
      unique case (reg_addr)
        reset_init_pkg::CTRL_ADDR:   rdata_nxt = {7'h00, det_en_r};
        reset_init_pkg::WIDTH_ADDR:  rdata_nxt = width_r;
        reset_init_pkg::CAUSE_ADDR:  rdata_nxt = {4'h0, cause_r};
        reset_init_pkg::STATUS_ADDR: rdata_nxt = {pins_r, stby_r, power_r, core_hold, state_r};
        default:                     rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      det_en_r  <= reset_init_pkg::DET_EN_RST;
      width_r   <= reset_init_pkg::WIDTH_RST;
      cause_r   <= reset_init_pkg::CAUSE_RST;
      reg_rdata <= 8'h00;
    end else begin
      det_en_r  <= det_en_nxt;
      width_r   <= width_nxt;
      cause_r   <= cause_nxt;
      reg_rdata <= rdata_nxt;
    end
  end

  // Helper for checks only: cycles spent settling
  localparam int SETTLE_TOTAL = SETTLE_DIV * SETTLE_PULSES;
  logic [31:0] settle_len_r;
  always_ff @(posedge mclk) begin
    if (!nrst || state_r != reset_init_pkg::ST_SETTLE) begin
      settle_len_r <= 32'h0;
    end else begin
      settle_len_r <= settle_len_r + 32'h1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence power_init_s;
    init_cmd.apply && init_cmd.full_ctrl;
  endsequence
  sequence soft_init_s;
    init_cmd.apply && !init_cmd.full_ctrl;
  endsequence

  req_holds_a: assert property (
    any_req |=> core_hold && state_r == reset_init_pkg::ST_HOLD)
    else $error("reset request did not hold the core");
  pc_start_a: assert property (init_cmd.apply |-> init_cmd.pc_start == 16'h0000)
    else $error("start address is not zero");
  settle_len_a: assert property (state_r == reset_init_pkg::ST_SETTLE
    && state_nxt == reset_init_pkg::ST_RUN |-> settle_len_r == 32'(SETTLE_TOTAL - 1))
    else $error("settling wait has wrong length");
  // The move out of INIT depends on requests in the strobe cycle itself
  power_settles_a: assert property (power_init_s ##0 !any_req
    |=> state_r == reset_init_pkg::ST_SETTLE && core_hold)
    else $error("power reset skipped the settling wait");
  soft_direct_a: assert property (soft_init_s ##0 !any_req
    |=> state_r == reset_init_pkg::ST_RUN && !core_hold)
    else $error("soft reset did not start directly");
  ctrl_power_a: assert property (power_init_s |-> init_cmd.stack_index == 4'h5
    && init_cmd.timer1_irq_flag && init_cmd.timer1_run_enable
    && !init_cmd.interval_timer_irq_flag && init_cmd.port_latch_clear)
    else $error("power reset control defaults wrong");
  ctrl_soft_a: assert property (soft_init_s |-> init_cmd.stack_index == 4'h5
    && !init_cmd.timer1_clear && !init_cmd.port_latch_clear && !init_cmd.keep_memory)
    else $error("soft reset disturbed kept state");
  int_mirror_a: assert property ($changed(pins_r[reset_init_pkg::PIN_INT])
    |=> int_level == $past(pins_r[reset_init_pkg::PIN_INT]))
    else $error("interrupt level not mirrored");
  timer_init_a: assert property (init_cmd.apply |-> init_cmd.timer0_clear
    && init_cmd.modulo_value == 8'hff && init_cmd.conv_result_clear
    && init_cmd.ports_input)
    else $error("timer or converter initial state wrong");
  bitcnt_a: assert property (init_cmd.apply |-> init_cmd.bitcnt_load == $past(wdt_r)
    && init_cmd.bitcnt_value == 8'h40)
    else $error("interval counter load wrong");
  keep_a: assert property (init_cmd.apply
    |-> init_cmd.keep_memory == ($past(power_r) && $past(stby_r))
    && init_cmd.keep_window == init_cmd.keep_memory && init_cmd.keep_shift == init_cmd.keep_memory)
    else $error("standby retention wrong");
  supply_filter_a: assert property ($rose(sup_req_r)
    |-> $past(low_cnt_r) >= $past(width_r))
    else $error("supply reset before detection width");
  supply_release_a: assert property (!pins_r[reset_init_pkg::PIN_SUP_LOW] |=> !sup_req_r)
    else $error("supply reset not released");

endmodule

// [rtl/reset_init_pkg.sv]
// Constants, field layouts and carrier types for the reset and initialisation sequencer
package reset_init_pkg;

  // Register map, byte addresses on the plain register port
  localparam logic [3:0] CTRL_ADDR   = 4'h0;  // Detector enable
  localparam logic [3:0] WIDTH_ADDR  = 4'h4;  // Supply detection width in cycles
  localparam logic [3:0] CAUSE_ADDR  = 4'h8;  // Sticky reset causes, write one to clear
  localparam logic [3:0] STATUS_ADDR = 4'hc;  // Sequencer state, read only

  // Field positions
  localparam int CTRL_DET_EN_BIT = 0;
  localparam int CAUSE_PIN_BIT   = 0;
  localparam int CAUSE_SUP_BIT   = 1;
  localparam int CAUSE_WDT_BIT   = 2;
  localparam int CAUSE_STK_BIT   = 3;

  // Reset values of the software registers
  localparam logic       DET_EN_RST = 1'b1;
  localparam logic [7:0] WIDTH_RST  = 8'h04;
  localparam logic [3:0] CAUSE_RST  = 4'h0;

  // Values forced into the core at initialisation
  localparam logic [15:0] PC_START_VAL    = 16'h0000;
  localparam logic [3:0]  STACK_INIT_VAL  = 4'h5;
  localparam logic [7:0]  MODULO_INIT_VAL = 8'hff;
  localparam logic [7:0]  BITCNT_WDT_VAL  = 8'h40;

  // Oscillation settling: timer 1 pulses and system clock divider
  localparam int SETTLE_DIV_DEF    = 128;
  localparam int SETTLE_PULSES_DEF = 256;

  // Synchronised pin slots
  localparam int PIN_RESET_N = 0;
  localparam int PIN_SUP_LOW = 1;
  localparam int PIN_INT     = 2;
  localparam logic [2:0] PIN_IDLE = 3'h1;  // Reset pin high, supply fine, int low

  // Sequencer states, Gray along hold, init, settle, run
  typedef enum logic [1:0] {
    ST_HOLD   = 2'h0,
    ST_INIT   = 2'h1,
    ST_SETTLE = 2'h3,
    ST_RUN    = 2'h2
  } seq_state_t;

  // Initialisation command presented to the core for one cycle
  typedef struct packed {
    logic        apply;          // Strobe: load the values below
    logic        full_ctrl;      // Power class: all control bits to defaults
    logic [15:0] pc_start;       // Program counter start
    logic [3:0]  stack_index;    // Address stack pointer
    logic        timer1_irq_flag;
    logic        timer1_run_enable;
    logic        interval_timer_irq_flag;
    logic        ports_input;    // All ports to input mode
    logic        port_latch_clear;
    logic        keep_memory;    // Data memory except data_buffer_reg retained
    logic        keep_window;    // Window register retained
    logic        keep_shift;     // serial_shift_reg retained
    logic        timer0_clear;
    logic        timer1_clear;
    logic [7:0]  modulo_value;   // Loaded into both modulo registers
    logic        bitcnt_load;
    logic [7:0]  bitcnt_value;
    logic        conv_result_clear;  // conv_result_reg to zero
  } init_cmd_t;

endpackage

// [test/reset_source_model.sv]
// Model of the external reset source and the supply detector output
module reset_source_model (
  input  wire logic mclk,         // System clock
  output logic      reset_pin_n,  // External reset pin, pulled up when released
  output logic      supply_low    // High while the supply sits at or below threshold
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle: pin released to its pull-up level, supply well above threshold
  initial begin
    reset_pin_n = 1'b1;
    supply_low  = 1'b0;
  end

  // Hold the reset pin low for n cycles, then release it
  task automatic pin_low(input int n);
    @(posedge mclk) reset_pin_n <= 1'b0;
    repeat (n) @(posedge mclk);
    reset_pin_n <= 1'b1;
  endtask

  // Report a low supply for n cycles; a short dip is a legal glitch
  task automatic supply_dip(input int n);
    @(posedge mclk) supply_low <= 1'b1;
    repeat (n) @(posedge mclk);
    supply_low <= 1'b0;
  endtask
endmodule

// [test/reset_init_sequencer_test.sv]
// Self-checking bench for the reset and initialisation sequencer
module reset_init_sequencer_test;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int DIV    = 2;          // Shortened divider keeps the run brief
  localparam int PUL    = 4;          // Shortened pulse count
  localparam int SETTLE = DIV * PUL;  // Settling wait in cycles

  logic                      mclk, nrst, reset_pin_n, supply_low, int_pin;
  logic                      wdt_overflow, stack_fault, standby, reg_wr, reg_rd;
  logic [3:0]                reg_addr;
  logic [7:0]                reg_wdata, reg_rdata, rd;
  logic                      core_hold, int_level;
  reset_init_pkg::init_cmd_t init_cmd, cmd;
  int                        bad_count, cmp_count, n;

  // Free-running 200 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  reset_source_model u_src (.mclk(mclk), .reset_pin_n(reset_pin_n), .supply_low(supply_low));

  reset_init_sequencer #(.SETTLE_DIV(DIV), .SETTLE_PULSES(PUL)) u_dut (
    .mclk(mclk), .nrst(nrst), .reset_pin_n(reset_pin_n), .supply_low(supply_low),
    .int_pin(int_pin), .wdt_overflow(wdt_overflow), .stack_fault(stack_fault),
    .standby(standby), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_hold(core_hold), .int_level(int_level),
    .init_cmd(init_cmd));

  // Verdict and end of run
  task automatic test_done();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Compare with case equality so unknowns never match
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask

  // A wait that runs out is a failure and ends the run
  task automatic give_up(input string msg);
    bad_count++;
    $display("CHECK FAILED at %0t: timeout on %s", $time, msg);
    test_done();
  endtask

  // Register write: one cycle with the strobe high
  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Register read: data stand only in the cycle after the strobe
  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Catch the one-cycle initialisation strobe
  task automatic wait_apply(input int bound);
    repeat (bound) begin
      @(posedge mclk);
      #1 if (init_cmd.apply === 1'b1) begin
        cmd = init_cmd;
        return;
      end
    end
    give_up("apply");
  endtask

  // Count cycles after the strobe until the core is let go
  task automatic wait_run(input int bound, output int cnt);
    for (cnt = 0; cnt < bound; cnt++) begin
      @(posedge mclk);
      #1 if (core_hold === 1'b0) return;
    end
    give_up("run");
  endtask

  // Judge the captured command against the reset class
  task automatic check_cmd(input logic pwr, input logic keep, input logic wdt);
    check(cmd.pc_start, 16'h0000, "pc start");
    check(cmd.stack_index, 4'h5, "stack index");
    check(cmd.full_ctrl, pwr, "control class");
    check(cmd.ports_input, 1'b1, "ports input");
    check(cmd.port_latch_clear, pwr, "latch clear");
    check(cmd.timer0_clear, 1'b1, "timer 0 clear");
    check(cmd.timer1_clear, pwr, "timer 1 clear");
    check(cmd.modulo_value, 8'hff, "modulo");
    check(cmd.conv_result_clear, 1'b1, "converter clear");
    check({cmd.keep_memory, cmd.keep_window}, {keep, keep}, "memory keep");
    check(cmd.keep_shift, keep, "shift keep");
    check(cmd.bitcnt_load, wdt, "interval load");
    if (wdt) check(cmd.bitcnt_value, 8'h40, "interval value");
    if (pwr) begin
      check({cmd.timer1_irq_flag, cmd.timer1_run_enable}, 2'h3, "timer 1 bits");
      check(cmd.interval_timer_irq_flag, 1'b0, "interval flag");
    end
  endtask

  // Power-up is a pin-class reset followed by the full settling wait
  task automatic s_power_up();
    wait_apply(30);
    check_cmd(1'b1, 1'b0, 1'b0);
    wait_run(SETTLE + 6, n);
    check(n, SETTLE, "settle length");
  endtask

  // Defaults, unmapped place, and the one-cycle read window
  task automatic s_regs();
    reg_read(reset_init_pkg::CTRL_ADDR, rd);
    check(rd, 8'h01, "detector enable");
    reg_read(reset_init_pkg::WIDTH_ADDR, rd);
    check(rd, 8'h04, "width default");
    @(posedge mclk);
    #1 check(reg_rdata, 8'h00, "read window");
    reg_write(reset_init_pkg::WIDTH_ADDR, 8'h07);
    reg_read(reset_init_pkg::WIDTH_ADDR, rd);
    check(rd, 8'h07, "width write");
    reg_write(reset_init_pkg::WIDTH_ADDR, 8'h04);
    // Running, power class, pins idle: {3'b001, 0, 1, 0, 2'h2}
    reg_read(reset_init_pkg::STATUS_ADDR, rd);
    check(rd, 8'h2a, "status after start");
    reg_write(4'h2, 8'h5a);
    reg_read(4'h2, rd);
    check(rd, 8'h00, "unmapped");
  endtask

  // Watchdog (wdt=1) or stack fault: no settle, cause recorded
  task automatic s_soft(input logic wdt);
    reg_write(reset_init_pkg::CAUSE_ADDR, 8'h0f);
    @(posedge mclk);
    if (wdt) wdt_overflow <= 1'b1; else stack_fault <= 1'b1;
    @(posedge mclk);
    wdt_overflow <= 1'b0; stack_fault <= 1'b0;
    wait_apply(4);
    check_cmd(1'b0, 1'b0, wdt);
    @(posedge mclk);
    #1 check(core_hold, 1'b0, "no settle");
    reg_read(reset_init_pkg::CAUSE_ADDR, rd);
    check(rd, wdt ? 8'h04 : 8'h08, "cause");
  endtask

  // Pin reset while in standby keeps memory, window and shift register
  task automatic s_pin_standby();
    @(posedge mclk);
    standby <= 1'b1;
    u_src.pin_low(6);
    #1 check(core_hold, 1'b1, "pin holds core");
    wait_apply(20);
    check_cmd(1'b1, 1'b1, 1'b0);
    wait_run(SETTLE + 6, n);
    check(n, SETTLE, "pin settle");
    // Standby only matters as a reset arrives, so it drops once running
    @(posedge mclk);
    standby <= 1'b0;
  endtask

  // Short dip ignored; long dip resets like the pin
  task automatic s_supply();
    reg_write(reset_init_pkg::CTRL_ADDR, 8'h00);
    u_src.supply_dip(12);
    repeat (10) @(posedge mclk);
    #1 check(core_hold, 1'b0, "detector off");
    reg_write(reset_init_pkg::CTRL_ADDR, 8'h01);
    u_src.supply_dip(2);
    repeat (10) @(posedge mclk);
    #1 check(core_hold, 1'b0, "glitch ignored");
    reg_write(reset_init_pkg::CAUSE_ADDR, 8'h0f);
    u_src.supply_dip(12);
    #1 check(core_hold, 1'b1, "supply holds core");
    wait_apply(30);
    check_cmd(1'b1, 1'b0, 1'b0);
    wait_run(SETTLE + 6, n);
    check(n, SETTLE, "supply settle");
    reg_read(reset_init_pkg::CAUSE_ADDR, rd);
    check(rd, 8'h02, "supply cause");
  endtask

  // Interrupt level follows the pin both ways
  task automatic s_int();
    @(posedge mclk);
    int_pin <= 1'b1;
    repeat (8) @(posedge mclk);
    #1 check(int_level, 1'b1, "int high");
    @(posedge mclk);
    int_pin <= 1'b0;
    repeat (8) @(posedge mclk);
    #1 check(int_level, 1'b0, "int low");
  endtask

  // Mid-run reset: outputs go idle, then the start settles like a pin reset
  task automatic s_mid_reset();
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 check({core_hold, int_level, reg_rdata}, 10'h200, "reset outputs");
    check(init_cmd.apply, 1'b0, "reset apply");
    @(posedge mclk);
    nrst <= 1'b1;
    wait_apply(30);
    check_cmd(1'b1, 1'b0, 1'b0);
    wait_run(SETTLE + 6, n);
    check(n, SETTLE, "reset settle");
  endtask

  // Main sequence
  initial begin
    bad_count    = 0;
    cmp_count    = 0;
    nrst         = 1'b0;
    int_pin      = 1'b0;
    wdt_overflow = 1'b0;
    stack_fault  = 1'b0;
    standby      = 1'b0;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    reg_addr     = 4'h0;
    reg_wdata    = 8'h00;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    s_power_up();
    s_regs();
    s_soft(1'b1);
    s_soft(1'b0);
    s_pin_standby();
    s_supply();
    s_int();
    s_mid_reset();
    test_done();
  end
endmodule
